// >>> hdl/sfra_pkg.sv
// Constants shared by the serial field receive adapter
package sfra_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite slave)
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'hC;

  // ==========================================================================
  // Field positions inside the registers
  localparam int CMD_PAR_BIT = 8;
  localparam int CMD_BOC_BIT = 9;
  localparam int RD_PAR_BIT = 8;
  localparam int RD_VALID_BIT = 9;
  localparam int STAT_SVC_BIT = 10;
  localparam int STAT_BUSY_BIT = 11;
  localparam int CTRL_BCZ_BIT = 0;

  // ==========================================================================
  // Channel command codes
  localparam logic [7:0] CMD_TEST_IO = 8'h00;
  localparam logic [7:0] CMD_NOOP = 8'h03;
  localparam logic [7:0] CMD_SENSE = 8'h04;
  localparam logic [6:0] CMD_READ_LOW = 7'h02;
  localparam logic [6:0] CMD_TREAD_LOW = 7'h22;

  // ==========================================================================
  // Serial field layout
  localparam logic [3:0] FIELD_DATA_BITS = 4'hC;
  localparam logic [3:0] FIRST_BIT_COUNT = 4'h1;
  localparam logic [3:0] TAGS_SOM = 4'h8;
  localparam logic [3:0] TAGS_MALF = 4'h1;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SFRA_IDLE = 2'b00,
    SFRA_READ = 2'b01,
    SFRA_SENSE = 2'b11
  } sfra_mode_t;

endpackage : sfra_pkg

// >>> hdl/sfra_top.sv
// Serial field receive adapter: field assembly, channel commands, AXI regs
// Function
// - Test I/O returns pending status, else zero
// - Unknown good-parity code: command reject, unit check
// - No-op ends at once with channel/device end
// - Sense requests service, sends sense, then terminates
// - Read commands ignore the modifier bit
// - Ignore data and end before first start
// - First field bit clears tags, counter to one
// - First four bits low byte one, rest byte two
// - Tag order start, end, parity error, malfunction
// - Check field odd parity, flag tag 2
// - Remembered parity error sets tag 3 at end
// - End on bit twelve sets tag 1, clears 0
// - Each channel byte carries generated odd parity
// - Request service, burst byte one then two
// - After end field, wait for new start
// - Read ends on zero byte count service or on overrun
// - Second start restarts, partial field dropped
// - Abnormal last field sends both bytes or none
// - Overrun sets unit check, overrun, terminates read
// - Misplaced end makes tags 0001, bytes still sent
// - Overrun when bit twelve finds bytes untaken
// - Status bits 4 5 6, cleared when taken
// - Sense bits 0 2 5, others unused
`timescale 1ns/1ns

module sfra_top (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic som_line_i,
  input wire logic eom_line_i,
  input wire logic data_line_i,
  input wire logic strobe_line_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic svc_req_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0] som_s;
    logic [1:0] eom_s;
    logic [1:0] dat_s;
    logic [2:0] stb_s;
    sfra_pkg::sfra_mode_t mode;
    logic active;
    logic [3:0] cnt;
    logic [3:0] tag;
    logic [11:0] shf;
    logic som_fld;
    logic end_msg;
    logic msg_err;
    logic [7:0] b1;
    logic [7:0] b2;
    logic pend;
    logic idx;
    logic ovr_wait;
    logic ce_de;
    logic uc;
    logic sn_rej;
    logic sn_boc;
    logic sn_ovr;
    logic bcz;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [9:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic svc_req;
  } sfra_state_t;

  sfra_state_t state_reg;
  sfra_state_t state_next;

  // Odd parity bit for a byte
  function automatic logic sfra_odd_par(input logic [7:0] b);
    sfra_odd_par = ~(^b);
  endfunction : sfra_odd_par

  // Bit 0 of the channel numbering is the byte's most significant bit
  function automatic logic [7:0] sfra_status_byte(input sfra_state_t s);
    sfra_status_byte = {4'h0, s.ce_de, s.ce_de, s.uc, 1'b0};
  endfunction : sfra_status_byte

  function automatic logic [7:0] sfra_sense_byte(input sfra_state_t s);
    sfra_sense_byte = {s.sn_rej, 1'b0, s.sn_boc, 2'b00, s.sn_ovr,
                       2'b00};
  endfunction : sfra_sense_byte

  always_comb begin
    logic stb_edge;
    logic bit_d;
    logic bit_som;
    logic bit_eom;
    logic fire;
    logic [7:0] code;
    logic [7:0] byte_out;
    logic perr;
    logic [3:0] tg;
    stb_edge = 1'b0;
    bit_d = 1'b0;
    bit_som = 1'b0;
    bit_eom = 1'b0;
    fire = 1'b0;
    code = 8'h00;
    byte_out = 8'h00;
    perr = 1'b0;
    tg = 4'h0;
    state_next = state_reg;

    // ========================================================================
    // Line synchronisers; edge found on the second and third strobe stages
    state_next.som_s = {state_reg.som_s[0], som_line_i};
    state_next.eom_s = {state_reg.eom_s[0], eom_line_i};
    state_next.dat_s = {state_reg.dat_s[0], data_line_i};
    state_next.stb_s = {state_reg.stb_s[1:0], strobe_line_i};
    stb_edge = state_reg.stb_s[1] & ~state_reg.stb_s[2];
    bit_d = state_reg.dat_s[1];
    bit_som = state_reg.som_s[1];
    bit_eom = state_reg.eom_s[1];

    // Status read clears first, so a write in the same cycle still sets
    if (s_axi_arvalid_i && state_reg.arready &&
        s_axi_araddr_i == sfra_pkg::ADDR_STATUS) begin
      state_next.ce_de = 1'b0;
      state_next.uc = 1'b0;
    end

    // ========================================================================
    // AXI4-Lite write channel
    if (s_axi_awvalid_i && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata_i[9:0];
      state_next.wstrb = s_axi_wstrb_i[1:0];
    end
    if (state_reg.bvalid && s_axi_bready_i) begin
      state_next.bvalid = 1'b0;
    end
    fire = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;
    if (fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = sfra_pkg::RESP_OKAY;
      code = state_reg.wdata[7:0];
      unique case (state_reg.aw_addr)
        sfra_pkg::ADDR_CMD: begin
          if (state_reg.wstrb == 2'b11) begin
            if (state_reg.wdata[sfra_pkg::CMD_BOC_BIT] ||
                (^state_reg.wdata[8:0]) == 1'b0) begin
              // Parity fault on the command: ignored, sense kept bit 2 only
              state_next.sn_boc = 1'b1;
              state_next.sn_rej = 1'b0;
              state_next.sn_ovr = 1'b0;
              state_next.uc = 1'b1;
            end else if (code == sfra_pkg::CMD_TEST_IO) begin
              state_next.mode = state_reg.mode;
            end else if (code == sfra_pkg::CMD_NOOP) begin
              state_next.ce_de = 1'b1;
              state_next.mode = sfra_pkg::SFRA_IDLE;
            end else if (code == sfra_pkg::CMD_SENSE) begin
              state_next.mode = sfra_pkg::SFRA_SENSE;
              state_next.idx = 1'b0;
            end else if (code[6:0] == sfra_pkg::CMD_READ_LOW ||
                         code[6:0] == sfra_pkg::CMD_TREAD_LOW) begin
              // Modifier bit ignored; test read runs the normal path here
              state_next.mode = sfra_pkg::SFRA_READ;
              state_next.active = 1'b0;
              state_next.pend = 1'b0;
              state_next.idx = 1'b0;
              state_next.ovr_wait = 1'b0;
              state_next.sn_rej = 1'b0;
              state_next.sn_boc = 1'b0;
              state_next.sn_ovr = 1'b0;
            end else begin
              state_next.sn_rej = 1'b1;
              state_next.sn_boc = 1'b0;
              state_next.sn_ovr = 1'b0;
              state_next.uc = 1'b1;
            end
          end
        end
        sfra_pkg::ADDR_CTRL: begin
          if (state_reg.wstrb[0]) begin
            state_next.bcz = state_reg.wdata[sfra_pkg::CTRL_BCZ_BIT];
          end
        end
        sfra_pkg::ADDR_STATUS, sfra_pkg::ADDR_DATA: begin
          state_next.bresp = sfra_pkg::RESP_SLVERR;
        end
        default: begin
          state_next.bresp = sfra_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ========================================================================
    // AXI4-Lite read channel; reads of STATUS and DATA have side effects
    if (state_reg.rvalid && s_axi_rready_i) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = sfra_pkg::RESP_OKAY;
      state_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        sfra_pkg::ADDR_STATUS: begin
          byte_out = sfra_status_byte(state_reg);
          state_next.rdata[7:0] = byte_out;
          state_next.rdata[sfra_pkg::RD_PAR_BIT] = sfra_odd_par(byte_out);
          state_next.rdata[sfra_pkg::STAT_SVC_BIT] = state_reg.svc_req;
          state_next.rdata[sfra_pkg::STAT_BUSY_BIT] =
            (state_reg.mode != sfra_pkg::SFRA_IDLE);
        end
        sfra_pkg::ADDR_DATA: begin
          if (state_reg.mode == sfra_pkg::SFRA_SENSE) begin
            byte_out = sfra_sense_byte(state_reg);
            state_next.rdata[7:0] = byte_out;
            state_next.rdata[sfra_pkg::RD_PAR_BIT] = sfra_odd_par(byte_out);
            state_next.rdata[sfra_pkg::RD_VALID_BIT] = 1'b1;
            state_next.ce_de = 1'b1;
            state_next.mode = sfra_pkg::SFRA_IDLE;
          end else if (state_reg.mode == sfra_pkg::SFRA_READ &&
                       state_reg.pend) begin
            if (!state_reg.idx && state_reg.bcz) begin
              // Count gone to zero: no byte moves, the read ends
              state_next.ce_de = 1'b1;
              state_next.mode = sfra_pkg::SFRA_IDLE;
              state_next.pend = 1'b0;
              state_next.active = 1'b0;
            end else begin
              byte_out = state_reg.idx ? state_reg.b2 : state_reg.b1;
              state_next.rdata[7:0] = byte_out;
              state_next.rdata[sfra_pkg::RD_PAR_BIT] =
                sfra_odd_par(byte_out);
              state_next.rdata[sfra_pkg::RD_VALID_BIT] = 1'b1;
              state_next.idx = ~state_reg.idx;
              if (state_reg.idx) begin
                state_next.pend = 1'b0;
              end
            end
          end
        end
        sfra_pkg::ADDR_CMD: begin
          state_next.rdata[7:0] = sfra_sense_byte(state_reg);
        end
        sfra_pkg::ADDR_CTRL: begin
          state_next.rdata[sfra_pkg::CTRL_BCZ_BIT] = state_reg.bcz;
        end
        default: begin
          state_next.rresp = sfra_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ========================================================================
    // Field assembly, one step per detected strobe edge
    if (state_reg.mode == sfra_pkg::SFRA_READ && stb_edge) begin
      if (bit_som) begin
        // Any start resets the assembly; partial data is dropped
        state_next.active = 1'b1;
        state_next.cnt = sfra_pkg::FIRST_BIT_COUNT;
        state_next.tag = sfra_pkg::TAGS_SOM;
        state_next.shf = {11'h000, bit_d};
        state_next.som_fld = 1'b1;
        state_next.end_msg = 1'b0;
        state_next.msg_err = 1'b0;
      end else if (state_reg.active) begin
        if (state_reg.cnt == 4'h0) begin
          state_next.cnt = sfra_pkg::FIRST_BIT_COUNT;
          state_next.tag = 4'h0;
          state_next.shf = {11'h000, bit_d};
          state_next.som_fld = 1'b0;
        end else if (state_reg.cnt < sfra_pkg::FIELD_DATA_BITS) begin
          state_next.shf = {state_reg.shf[10:0], bit_d};
          state_next.cnt = state_reg.cnt + 4'h1;
          if (state_reg.cnt == sfra_pkg::FIELD_DATA_BITS - 4'h1) begin
            if (bit_eom && !state_reg.som_fld) begin
              state_next.tag = {1'b0, 1'b1, state_reg.tag[1:0]};
              state_next.end_msg = 1'b1;
            end else if (bit_eom) begin
              state_next.tag = sfra_pkg::TAGS_MALF;
              state_next.end_msg = 1'b1;
            end
            if (state_reg.pend) begin
              // Untaken bytes: new field lost, read ends once drained
              state_next.sn_ovr = 1'b1;
              state_next.ovr_wait = 1'b1;
              state_next.active = 1'b0;
            end
          end else if (bit_eom) begin
            state_next.tag = sfra_pkg::TAGS_MALF;
          end
        end else begin
          // Thirteenth bit is the field parity
          perr = ~(^{state_reg.shf, bit_d});
          tg = state_reg.tag;
          if (tg != sfra_pkg::TAGS_MALF) begin
            tg[1] = perr;
          end
          if (state_reg.end_msg && (state_reg.msg_err | perr)) begin
            tg[0] = 1'b1;
          end
          state_next.msg_err = state_reg.msg_err | perr;
          state_next.b1 = {tg[3], tg[2], tg[1], tg[0],
                           state_reg.shf[11:8]};
          state_next.b2 = state_reg.shf[7:0];
          state_next.pend = 1'b1;
          state_next.idx = 1'b0;
          state_next.cnt = 4'h0;
          if (state_reg.end_msg) begin
            state_next.active = 1'b0;
          end
        end
      end
    end

    // ========================================================================
    // Overrun termination after the previous field has fully drained
    if (state_reg.ovr_wait && !state_next.pend &&
        state_next.mode == sfra_pkg::SFRA_READ) begin
      state_next.uc = 1'b1;
      state_next.ce_de = 1'b1;
      state_next.mode = sfra_pkg::SFRA_IDLE;
      state_next.ovr_wait = 1'b0;
    end

    state_next.svc_req = state_next.mode == sfra_pkg::SFRA_SENSE ||
      (state_next.mode == sfra_pkg::SFRA_READ && state_next.pend);
    state_next.awready = ~state_next.aw_got & ~state_next.bvalid;
    state_next.wready = ~state_next.w_got & ~state_next.bvalid;
    state_next.arready = ~state_next.rvalid;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready_o = state_reg.awready;
  assign s_axi_wready_o = state_reg.wready;
  assign s_axi_bresp_o = state_reg.bresp;
  assign s_axi_bvalid_o = state_reg.bvalid;
  assign s_axi_arready_o = state_reg.arready;
  assign s_axi_rdata_o = state_reg.rdata;
  assign s_axi_rresp_o = state_reg.rresp;
  assign s_axi_rvalid_o = state_reg.rvalid;
  assign svc_req_o = state_reg.svc_req;

endmodule : sfra_top

// >>> testbench/sfra_chk.sv
// Assertion checker for the serial field receive adapter ports
`timescale 1ns/1ns
module sfra_chk (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic svc_req_o
);
  // ==========================================================================
  // Address of the read in flight and byte pair phase
  logic [3:0] rd_a_reg;
  logic ph_reg;
  logic dat_rd;
  logic [7:0] rb;
  assign rb = s_axi_rdata_o[7:0];
  assign dat_rd = s_axi_rvalid_o && s_axi_rready_i &&
    rd_a_reg == sfra_pkg::ADDR_DATA && s_axi_rdata_o[sfra_pkg::RD_VALID_BIT];
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_a_reg <= 4'h0;
      ph_reg <= 1'b0;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        rd_a_reg <= s_axi_araddr_i;
      end
      // Any write may start a new command, so pairing restarts
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        ph_reg <= 1'b0;
      end else if (dat_rd) begin
        ph_reg <= ~ph_reg;
      end
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_byte1; dat_rd && !ph_reg; endsequence
  sequence s_byte2; dat_rd && ph_reg; endsequence
  sequence s_stat_rd; s_axi_rvalid_o && rd_a_reg == sfra_pkg::ADDR_STATUS;
  endsequence
  sequence s_sense_rd; s_axi_rvalid_o && rd_a_reg == sfra_pkg::ADDR_CMD;
  endsequence
  AST_BVALID_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bvalid lost");
  AST_RVALID_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rvalid lost");
  AST_SVC_HOLD: assert property (
    svc_req_o && s_axi_awready_o && !s_axi_awvalid_i &&
    !(s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == sfra_pkg::ADDR_DATA) |=> svc_req_o)
    else $error("service request dropped without a data read");
  AST_SVC_DROP: assert property (s_byte2 |=> !svc_req_o)
    else $error("service request stayed after second byte");
  AST_DATA_PAR: assert property (
    dat_rd |-> s_axi_rdata_o[sfra_pkg::RD_PAR_BIT] == ~^rb)
    else $error("data byte parity not odd");
  AST_STAT_PAR: assert property (
    s_stat_rd |-> s_axi_rdata_o[sfra_pkg::RD_PAR_BIT] == ~^rb)
    else $error("status byte parity not odd");
  AST_STAT_BITS: assert property (
    s_stat_rd |-> rb[7:4] == 4'h0 && !rb[0] && rb[3] == rb[2])
    else $error("status byte layout wrong");
  AST_SENSE_BITS: assert property (
    s_sense_rd |-> !rb[6] && rb[4:3] == 2'h0 && rb[1:0] == 2'h0)
    else $error("unused sense bit set");
  AST_TAG_SOM_EOM: assert property (s_byte1 |-> !(rb[7] && rb[6]))
    else $error("start and end tags both set");
  AST_TAG_MALF: assert property (
    s_byte1 ##0 (rb[6] && rb[5]) |-> rb[4])
    else $error("malfunction tag missing on end field");
endmodule : sfra_chk

// >>> testbench/sfra_sender.sv
// Model of the radar receive channel sending framed serial fields
`timescale 1ns/1ns
module sfra_sender (
  input wire logic core_clk_i,
  output logic som_line_o,
  output logic eom_line_o,
  output logic data_line_o,
  output logic strobe_line_o
);
  initial begin
    som_line_o = 1'b0;
    eom_line_o = 1'b0;
    data_line_o = 1'b0;
    strobe_line_o = 1'b0;
  end
  // Half a bit period of the 160 ns link clock
  task automatic half();
    repeat (8) @(posedge core_clk_i);
  endtask : half
  // Field interval between messages
  task automatic gap();
    repeat (26) half();
  endtask : gap
  // Strobe stands still between fields; nbits below 13 cuts a field short
  task automatic send(input logic [11:0] d, input logic start_of_message_line, input int eom_at,
                      input logic bad, input int nbits);
    logic b;
    b = 1'b0;
    for (int i = 1; i <= nbits; i++) begin
      b = (i <= 12) ? d[12 - i] : (~^d) ^ bad;
      som_line_o <= start_of_message_line && i == 1;
      eom_line_o <= i == eom_at;
      data_line_o <= b;
      half();
      strobe_line_o <= 1'b1;
      half();
      strobe_line_o <= 1'b0;
    end
    som_line_o <= 1'b0;
    eom_line_o <= 1'b0;
    data_line_o <= ~b;
    // Idle half a bit so a following call starts on a fresh step
    half();
  endtask : send
endmodule : sfra_sender

// >>> testbench/test_serial_field_receive_adapter.sv
// Self-checking bench for the serial field receive adapter
`timescale 1ns/1ns
module test_serial_field_receive_adapter;
  logic clk;
  logic srst = 1'b1;
  logic start_of_message_line, end_of_message_line, dat, stb;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, svc;
  logic [1:0] bresp, rresp, wresp, rrsp;
  logic [31:0] rdata, rdv;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;

  sfra_top DUT (
    .core_clk_i(clk), .srst_i(srst), .ce_i(1'b1), .som_line_i(start_of_message_line),
    .eom_line_i(end_of_message_line), .data_line_i(dat), .strobe_line_i(stb),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .svc_req_o(svc));
  sfra_sender PM (.core_clk_i(clk), .som_line_o(start_of_message_line), .eom_line_o(end_of_message_line),
    .data_line_o(dat), .strobe_line_o(stb));

  // ==========================================================================
  // Bus and compare tasks; ready and answers are sampled settled at negedge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      wresp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      // Ready follows a seen answer, so the slave must hold it a cycle
      if (bvalid) bready <= !tb;
    end
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic tk, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      tk = arvalid && arready;
      tr = rvalid && rready;
      rdv = rdata;
      rrsp = rresp;
      @(posedge clk);
      if (tk) arvalid <= 1'b0;
      if (rvalid) rready <= !tr;
    end
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c, input logic bad);
    wr(sfra_pkg::ADDR_CMD, 32'({(~^c) ^ bad, c}));
  endtask : cmd
  task automatic stat(input logic [7:0] s);
    rd(sfra_pkg::ADDR_STATUS);
    chk(32'(rdv[8:0]), 32'({~^s, s}));
  endtask : stat
  task automatic sense(input logic [7:0] s);
    rd(sfra_pkg::ADDR_CMD);
    chk(32'(rdv[7:0]), 32'(s));
  endtask : sense
  task automatic pair(input logic [11:0] d, input logic [3:0] tags);
    rd(sfra_pkg::ADDR_DATA);
    chk(32'(rdv[9:0]), 32'({2'b10 | 2'(~^{tags, d[11:8]}), tags, d[11:8]}));
    rd(sfra_pkg::ADDR_DATA);
    chk(32'(rdv[9:0]), 32'({2'b10 | 2'(~^d[7:0]), d[7:0]}));
    chk(32'(svc), 32'h0000_0000);
  endtask : pair

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    stat(8'h00);
    sense(8'h00);
    wr(sfra_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(32'(wresp), 32'(sfra_pkg::RESP_SLVERR));
    rd(4'h2);
    chk(32'(rrsp), 32'(sfra_pkg::RESP_SLVERR));
    wr(sfra_pkg::ADDR_CTRL, 32'h0000_0001);
    chk(32'(wresp), 32'(sfra_pkg::RESP_OKAY));
    rd(sfra_pkg::ADDR_CTRL);
    chk(32'(rdv[0]), 32'h0000_0001);
    wr(sfra_pkg::ADDR_CTRL, 32'h0000_0000);
  endtask : t_reset
  task automatic t_cmds();
    logic [7:0] bad_codes [4] = '{8'h01, 8'h05, 8'h42, 8'hFF};
    cmd(sfra_pkg::CMD_TEST_IO, 1'b0);
    stat(8'h00);
    cmd(sfra_pkg::CMD_NOOP, 1'b0);
    cmd(sfra_pkg::CMD_TEST_IO, 1'b0);
    stat(8'h0C);
    stat(8'h00);
    foreach (bad_codes[i]) begin
      cmd(bad_codes[i], 1'b0);
      stat(8'h02);
      sense(8'h80);
    end
    cmd(sfra_pkg::CMD_NOOP, 1'b1);
    stat(8'h02);
    cmd(sfra_pkg::CMD_SENSE, 1'b0);
    chk(32'(svc), 32'h0000_0001);
    rd(sfra_pkg::ADDR_DATA);
    chk(32'(rdv[9:0]), 32'h0000_0220);
    stat(8'h0C);
  endtask : t_cmds
  task automatic t_read();
    cmd({1'b1, sfra_pkg::CMD_READ_LOW}, 1'b0);
    PM.send(12'hFFF, 1'b0, 12, 1'b0, 13);
    chk(32'(svc), 32'h0000_0000);
    PM.gap();
    PM.send(12'hA5C, 1'b1, 0, 1'b0, 13);
    chk(32'(svc), 32'h0000_0001);
    rd(sfra_pkg::ADDR_STATUS);
    chk(32'(rdv[11:8]), 32'h0000_000D);
    pair(12'hA5C, 4'b1000);
    PM.send(12'h3F0, 1'b0, 12, 1'b1, 13);
    pair(12'h3F0, 4'b0111);
    PM.send(12'h123, 1'b0, 0, 1'b0, 13);
    chk(32'(svc), 32'h0000_0000);
    stat(8'h00);
    PM.gap();
  endtask : t_read
  task automatic t_abnormal();
    cmd({1'b1, sfra_pkg::CMD_TREAD_LOW}, 1'b0);
    PM.send(12'hFFF, 1'b1, 0, 1'b0, 6);
    PM.send(12'h9AB, 1'b1, 0, 1'b0, 13);
    pair(12'h9AB, 4'b1000);
    PM.send(12'h456, 1'b0, 5, 1'b0, 13);
    pair(12'h456, 4'b0001);
    PM.gap();
  endtask : t_abnormal
  task automatic t_overrun();
    PM.send(12'h111, 1'b1, 0, 1'b0, 13);
    PM.send(12'h222, 1'b0, 12, 1'b0, 13);
    pair(12'h111, 4'b1000);
    stat(8'h0E);
    sense(8'h04);
    PM.gap();
  endtask : t_overrun
  task automatic t_count_zero();
    cmd(8'h02, 1'b0);
    wr(sfra_pkg::ADDR_CTRL, 32'h0000_0001);
    PM.send(12'h777, 1'b1, 0, 1'b0, 13);
    rd(sfra_pkg::ADDR_DATA);
    chk(32'(rdv[9]), 32'h0000_0000);
    stat(8'h0C);
    wr(sfra_pkg::ADDR_CTRL, 32'h0000_0000);
  endtask : t_count_zero

  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs about 3100 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_cmds();
    t_read();
    t_abnormal();
    t_overrun();
    t_count_zero();
    end_sim();
  end
endmodule : test_serial_field_receive_adapter

bind sfra_top sfra_chk CHK (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .svc_req_o(svc_req_o));
